// ---- core/asof_formatter.sv ----
// Contract
// - Stabilizer on: sample on rising edge only, falling edge ignored.
// - Stabilizer needs one hundred input cycles to relock after a stop.
// - Output-select level picks full CMOS, demux CMOS, low-power or standard LVDS.
// - Format level picks binary or two's complement and stabilizer on or off.
// - Range flag high on over- or under-range; per bus or single.
// - Forwarded clock pair; first-bus data change as first falls, second rises; demux second-bus data change as first rises.
// - Demux mode forwarded clocks toggle at half the encode rate.
// - Scramble XORs every bit above the LSB with the LSB.
// - Track from falling encode edge, hold at following rising edge.
`timescale 1ns/1ps
`default_nettype none
module asof_formatter
    import asof_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int LOCK_COUNT = LOCK_CYCLES
) (
    // Clock, reset, enable.
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Converter side.
    input wire logic SAMPLE_CLOCK_IN,
    input wire logic [WIDTH-1:0] CONV_CODE,
    input wire logic CONV_OVER_RANGE,
    input wire logic [1:0] OUTPUT_SELECT,
    input wire logic [1:0] FORMAT_SELECT,
    input wire logic SCRAMBLE_ENABLE,
    // Output pins.
    output logic [WIDTH-1:0] DATA_FIRST_BUS,
    output logic [WIDTH-1:0] DATA_SECOND_BUS,
    output logic RANGE_FLAG_FIRST_BUS,
    output logic RANGE_FLAG_SECOND_BUS,
    output logic RANGE_FLAG,
    output logic FORWARDED_CLOCK_FIRST,
    output logic FORWARDED_CLOCK_SECOND,
    output logic TRACK_PHASE,
    output logic IRQ,
    // AXI4-Lite slave.
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    function automatic logic [WIDTH-1:0] format_code(input logic [WIDTH-1:0] code,
            input logic twos, input logic scr);
        logic [WIDTH-1:0] v;
        v = code;
        if (twos) begin
            v[WIDTH-1] = ~v[WIDTH-1];
        end
        if (scr) begin
            v[WIDTH-1:1] = v[WIDTH-1:1] ^ {(WIDTH-1){v[0]}};
        end
        return v;
    endfunction

    logic [2:0] sclk_sync;
    logic [1:0] osel_s1, osel_s2, fsel_s1, fsel_s2;
    logic scr_s1, scr_s2, ovr_s1, ovr_s2;
    logic [WIDTH-1:0] code_s1, code_s2;
    logic sclk_rise, sclk_fall;
    logic twos, stab_on;
    asof_out_mode_t out_mode;
    asof_fmt_mode_t fmt_mode;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sclk_sync <= 3'b000;
            osel_s1 <= 2'b00;
            osel_s2 <= 2'b00;
            fsel_s1 <= 2'b00;
            fsel_s2 <= 2'b00;
            scr_s1 <= 1'b0;
            scr_s2 <= 1'b0;
            ovr_s1 <= 1'b0;
            ovr_s2 <= 1'b0;
            code_s1 <= '0;
            code_s2 <= '0;
        end else if (CE) begin
            sclk_sync <= {sclk_sync[1:0], SAMPLE_CLOCK_IN};
            osel_s1 <= OUTPUT_SELECT;
            osel_s2 <= osel_s1;
            fsel_s1 <= FORMAT_SELECT;
            fsel_s2 <= fsel_s1;
            scr_s1 <= SCRAMBLE_ENABLE;
            scr_s2 <= scr_s1;
            ovr_s1 <= CONV_OVER_RANGE;
            ovr_s2 <= ovr_s1;
            code_s1 <= CONV_CODE;
            code_s2 <= code_s1;
        end
    end

    // Edge detection reads only the second and third stages.
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign out_mode = asof_out_mode_t'(osel_s2);
    assign fmt_mode = asof_fmt_mode_t'(fsel_s2);
    assign twos = (fmt_mode == FMT_TC_STAB) || (fmt_mode == FMT_TC_NOSTAB);
    assign stab_on = (fmt_mode == FMT_OB_STAB) || (fmt_mode == FMT_TC_STAB);

    // Stabilizer lock: counts rising edges after a long stop.
    asof_lock_t lock_state;
    logic [7:0] lock_cnt;
    logic [7:0] idle_cnt;
    logic lock_done;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lock_state <= LK_IDLE;
            lock_cnt <= 8'h00;
            idle_cnt <= 8'h00;
        end else if (CE) begin
            if (sclk_rise || sclk_fall) begin
                idle_cnt <= 8'h00;
            end else if (idle_cnt != STOP_CYCLES) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
            case (lock_state)
                LK_IDLE: begin
                    lock_cnt <= 8'h00;
                    if (sclk_rise) begin
                        lock_state <= LK_LOCKING;
                    end
                end
                LK_LOCKING: begin
                    if (idle_cnt == STOP_CYCLES) begin
                        lock_state <= LK_IDLE;
                    end else if (sclk_rise) begin
                        if (lock_cnt == 8'(LOCK_COUNT - 1)) begin
                            lock_state <= LK_LOCKED;
                        end
                        lock_cnt <= lock_cnt + 8'h01;
                    end
                end
                LK_LOCKED: begin
                    if (idle_cnt == STOP_CYCLES) begin
                        lock_state <= LK_IDLE;
                    end
                end
                default: lock_state <= LK_IDLE;
            endcase
        end
    end
    assign lock_done = !stab_on || (lock_state == LK_LOCKED);

    // Track phase: falling edge starts it, rising edge holds. Stabilizer ignores the
    // external falling edge and makes its own half a period after the rise.
    logic [7:0] half_cnt, per_cnt;
    logic int_fall;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            per_cnt <= 8'h00;
            half_cnt <= 8'h00;
        end else if (CE) begin
            if (sclk_rise) begin
                per_cnt <= 8'h01;
                half_cnt <= {1'b0, per_cnt[7:1]};
            end else begin
                if (per_cnt != 8'hFF) begin
                    per_cnt <= per_cnt + 8'h01;
                end
                if (half_cnt != 8'h00) begin
                    half_cnt <= half_cnt - 8'h01;
                end
            end
        end
    end
    assign int_fall = (half_cnt == 8'h01) && !sclk_rise;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            TRACK_PHASE <= 1'b0;
        end else if (CE) begin
            if (sclk_rise) begin
                TRACK_PHASE <= 1'b0;
            end else if (stab_on ? int_fall : sclk_fall) begin
                TRACK_PHASE <= 1'b1;
            end
        end
    end

    // Output path: sample on the rising edge only.
    logic [WIDTH-1:0] fmt_code;
    logic bus_sel;
    logic sample_evt;
    assign fmt_code = format_code(code_s2, twos, scr_s2);
    assign sample_evt = sclk_rise && lock_done;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            DATA_FIRST_BUS <= '0;
            DATA_SECOND_BUS <= '0;
            RANGE_FLAG_FIRST_BUS <= 1'b0;
            RANGE_FLAG_SECOND_BUS <= 1'b0;
            RANGE_FLAG <= 1'b0;
            bus_sel <= 1'b0;
        end else if (CE && sample_evt) begin
            case (out_mode)
                OUT_FULL_CMOS: begin
                    DATA_FIRST_BUS <= fmt_code;
                    RANGE_FLAG_FIRST_BUS <= ovr_s2;
                    bus_sel <= 1'b0;
                end
                OUT_DEMUX_CMOS: begin
                    if (!bus_sel) begin
                        DATA_FIRST_BUS <= fmt_code;
                        RANGE_FLAG_FIRST_BUS <= ovr_s2;
                    end else begin
                        DATA_SECOND_BUS <= fmt_code;
                        RANGE_FLAG_SECOND_BUS <= ovr_s2;
                    end
                    bus_sel <= ~bus_sel;
                end
                default: begin
                    DATA_FIRST_BUS <= fmt_code;
                    RANGE_FLAG <= ovr_s2;
                    bus_sel <= 1'b0;
                end
            endcase
        end
    end

    // Forwarded clocks: complementary; first-bus data change as first falls, demux second-bus data as it rises.
    logic fwd;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fwd <= 1'b0;
        end else if (CE) begin
            if (out_mode == OUT_DEMUX_CMOS) begin
                if (sample_evt && !bus_sel) begin
                    fwd <= 1'b0;
                end else if (sample_evt) begin
                    fwd <= 1'b1;
                end
            end else if (sample_evt) begin
                fwd <= 1'b0;
            end else if (stab_on ? int_fall : sclk_fall) begin
                fwd <= 1'b1;
            end
        end
    end
    assign FORWARDED_CLOCK_FIRST = fwd;
    assign FORWARDED_CLOCK_SECOND = ~fwd;

    // Registers and interrupts.
    logic [IRQ_W-1:0] irq_stat, irq_mask, irq_evt;
    logic [31:0] ctrl;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic wr_go, lock_prev;
    assign irq_evt = {stab_on & (lock_state == LK_LOCKED) & ~lock_prev, sample_evt & ovr_s2,
        sample_evt};
    // Readies drop while the clock enable is low, so no transfer is lost.
    assign S_AXI_AWREADY = CE && !aw_hold && !S_AXI_BVALID;
    assign S_AXI_WREADY = CE && !w_hold && !S_AXI_BVALID;
    assign S_AXI_ARREADY = CE && !S_AXI_RVALID;
    assign wr_go = aw_hold && w_hold && !S_AXI_BVALID;
    assign IRQ = |(irq_stat & irq_mask);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
            ctrl <= CTRL_RESET;
            irq_mask <= MASK_RESET[IRQ_W-1:0];
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold <= 1'b1;
                w_data <= S_AXI_WDATA;
            end
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= 2'b00;
                case (aw_addr)
                    REG_CTRL: ctrl <= w_data;
                    REG_IRQ_MASK: irq_mask <= w_data[IRQ_W-1:0];
                    REG_IRQ_STAT, REG_STATUS, REG_SAMPLE: S_AXI_BRESP <= 2'b00;
                    default: S_AXI_BRESP <= 2'b10;
                endcase
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_stat <= '0;
            lock_prev <= 1'b0;
        end else if (CE) begin
            lock_prev <= stab_on && (lock_state == LK_LOCKED);
            if (wr_go && aw_addr == REG_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat <= irq_stat | irq_evt;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'b00;
        end else if (CE) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                case (S_AXI_ARADDR)
                    REG_CTRL: S_AXI_RDATA <= ctrl;
                    REG_STATUS: S_AXI_RDATA <= {24'h00_0000, 1'b0, lock_done,
                        fsel_s2, osel_s2, scr_s2, bus_sel};
                    REG_IRQ_STAT: S_AXI_RDATA <= {29'h0, irq_stat};
                    REG_IRQ_MASK: S_AXI_RDATA <= {29'h0, irq_mask};
                    REG_SAMPLE: S_AXI_RDATA <= {16'h0000, DATA_FIRST_BUS};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- include/asof_pkg.sv ----
package asof_pkg;
    localparam int DATA_W = 16;
    localparam int LOCK_CYCLES = 100;
    localparam int SYNC_STAGES = 2;
    localparam logic [31:0] SCLK_PERIOD_NS = 32'h0000_00C8;
    localparam logic [7:0] STOP_CYCLES = 8'hFF;
    localparam logic [31:0] CLK_PERIOD_NS = 32'h0000_0019;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_SAMPLE = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam int IRQ_SAMPLE = 0;
    localparam int IRQ_RANGE = 1;
    localparam int IRQ_LOCK = 2;
    localparam int IRQ_W = 3;
    typedef enum logic [1:0] {
        OUT_FULL_CMOS = 2'b00,
        OUT_DEMUX_CMOS = 2'b01,
        OUT_LP_LVDS = 2'b10,
        OUT_LVDS = 2'b11
    } asof_out_mode_t;
    typedef enum logic [1:0] {
        FMT_OB_NOSTAB = 2'b00,
        FMT_OB_STAB = 2'b01,
        FMT_TC_STAB = 2'b10,
        FMT_TC_NOSTAB = 2'b11
    } asof_fmt_mode_t;
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_LOCKING = 2'b01,
        LK_LOCKED = 2'b11
    } asof_lock_t;
endpackage

// ---- test/asof_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module asof_chk
    import asof_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Watched pins.
    input wire logic SAMPLE_CLOCK_IN,
    input wire logic [1:0] OUTPUT_SELECT,
    input wire logic [1:0] FORMAT_SELECT,
    input wire logic [WIDTH-1:0] DATA_FIRST_BUS,
    input wire logic [WIDTH-1:0] DATA_SECOND_BUS,
    input wire logic RANGE_FLAG_FIRST_BUS,
    input wire logic FORWARDED_CLOCK_FIRST,
    input wire logic FORWARDED_CLOCK_SECOND,
    input wire logic TRACK_PHASE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N || !CE);
    property p_pair; FORWARDED_CLOCK_SECOND == !FORWARDED_CLOCK_FIRST; endproperty
    a_pair: assert property (p_pair) else $error("clock pair not complementary");
    property p_upd; $changed(DATA_FIRST_BUS) |-> !FORWARDED_CLOCK_FIRST; endproperty
    a_upd: assert property (p_upd) else $error("first bus moved with clock high");
    property p_flag; $changed(RANGE_FLAG_FIRST_BUS) |-> !FORWARDED_CLOCK_FIRST; endproperty
    a_flag: assert property (p_flag) else $error("flag moved with clock high");
    property p_alt;
        $changed(DATA_SECOND_BUS) && OUTPUT_SELECT == 2'b01 |-> $stable(DATA_FIRST_BUS);
    endproperty
    a_alt: assert property (p_alt) else $error("both buses moved together");
    property p_rise;
        $changed(DATA_FIRST_BUS) |-> $past(SAMPLE_CLOCK_IN, 3) && !$past(SAMPLE_CLOCK_IN, 4);
    endproperty
    a_rise: assert property (p_rise) else $error("data not timed from rising edge");
    property p_hold; $rose(SAMPLE_CLOCK_IN) |-> ##[1:5] !TRACK_PHASE; endproperty
    a_hold: assert property (p_hold) else $error("track not ended at rise");
    property p_track;
        $fell(SAMPLE_CLOCK_IN) && (FORMAT_SELECT == 2'b00 || FORMAT_SELECT == 2'b11)
            |-> ##[1:5] TRACK_PHASE;
    endproperty
    a_track: assert property (p_track) else $error("track not started at fall");
    property p_half;
        $changed(FORWARDED_CLOCK_FIRST) && OUTPUT_SELECT == 2'b01
            |=> $stable(FORWARDED_CLOCK_FIRST) [*5];
    endproperty
    a_half: assert property (p_half) else $error("demux clock too fast");
endmodule
bind asof_formatter asof_chk #(.WIDTH(WIDTH)) i_asof_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .SAMPLE_CLOCK_IN(SAMPLE_CLOCK_IN), .OUTPUT_SELECT(OUTPUT_SELECT),
    .FORMAT_SELECT(FORMAT_SELECT), .DATA_FIRST_BUS(DATA_FIRST_BUS),
    .DATA_SECOND_BUS(DATA_SECOND_BUS), .RANGE_FLAG_FIRST_BUS(RANGE_FLAG_FIRST_BUS),
    .FORWARDED_CLOCK_FIRST(FORWARDED_CLOCK_FIRST),
    .FORWARDED_CLOCK_SECOND(FORWARDED_CLOCK_SECOND), .TRACK_PHASE(TRACK_PHASE));
`default_nettype wire

// ---- test/asof_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module asof_far_model
    import asof_pkg::*;
(
    // Encode source.
    input wire logic run,
    output logic sclk,
    // Capture side.
    input wire logic fwd,
    input wire logic [DATA_W-1:0] data,
    input wire logic scr,
    output logic [DATA_W-1:0] cap
);
    // Toggles every 100 ns, so the pin stands low once run drops.
    always begin
        #100;
        sclk = (run || sclk === 1'b1) ? (sclk !== 1'b1) : 1'b0;
    end
    always @(posedge fwd) begin
        cap <= scr ? data ^ ({DATA_W{data[0]}} & 16'hFFFE) : data;
    end
endmodule
`default_nettype wire

// ---- test/asof_formatter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module asof_formatter_tb;
    import asof_pkg::*;
    logic CLK = 1'b0, RST_N = 1'b0, run = 1'b0, ovr = 1'b0, scr = 1'b0, ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sclk, fwd1, fwd2, rf1, rf2, rf, trk, irq;
    logic [15:0] code = 16'h0000, d1, d2, cap;
    logic [1:0] osel = 2'b00, fsel = 2'b00, bresp, rresp, bresp_pin, rresp_pin;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd, x = 32'h0000_003F;
    int error_cnt = 0, check_count = 0;
    always #12.5 CLK = ~CLK;
    asof_formatter #(.LOCK_COUNT(4)) i_asof_formatter (.CLK(CLK), .RST_N(RST_N), .CE(ce),
        .SAMPLE_CLOCK_IN(sclk), .CONV_CODE(code), .CONV_OVER_RANGE(ovr),
        .OUTPUT_SELECT(osel), .FORMAT_SELECT(fsel), .SCRAMBLE_ENABLE(scr),
        .DATA_FIRST_BUS(d1), .DATA_SECOND_BUS(d2), .RANGE_FLAG_FIRST_BUS(rf1),
        .RANGE_FLAG_SECOND_BUS(rf2), .RANGE_FLAG(rf), .FORWARDED_CLOCK_FIRST(fwd1),
        .FORWARDED_CLOCK_SECOND(fwd2), .TRACK_PHASE(trk), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp_pin), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp_pin),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    asof_far_model i_asof_far_model (.run(run), .sclk(sclk), .fwd(fwd1), .data(d1),
        .scr(scr), .cap(cap));
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where the rising-edge values have settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta, tw, tb;
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge CLK);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp_pin;
            @(posedge CLK);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        error_cnt++;
        end_sim();
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ta, tv;
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge CLK);
            ta = arvalid && arready;
            tv = rvalid;
            d = rdata;
            r = rresp_pin;
            @(posedge CLK);
            if (ta) arvalid <= 1'b0;
            if (tv) begin
                rready <= 1'b0;
                return;
            end
        end
        error_cnt++;
        end_sim();
    endtask
    initial begin
        repeat (60000) @(posedge CLK);
        error_cnt++;
        end_sim();
    end
    initial begin
        logic [31:0] v;
        logic [15:0] e, u;
        logic p, stab, last;
        int os, fs, sc;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        rdr(REG_CTRL, rd, rresp);
        chk("ctrl_reset", rd, CTRL_RESET);
        rdr(REG_IRQ_MASK, rd, rresp);
        chk("mask_reset", rd, MASK_RESET);
        v = rnd();
        wr(REG_CTRL, v, bresp);
        rdr(REG_CTRL, rd, rresp);
        chk("ctrl", rd, v);
        wr(8'h20, v, bresp);
        chk("bresp_unmapped", bresp, 2'b10);
        rdr(8'h20, rd, rresp);
        chk("rresp_unmapped", rresp, 2'b10);
        chk("rdata_unmapped", rd, 32'h0000_0000);
        $display("test registers done");
        for (int k = 0; k < 32; k++) begin
            os = k / 8;
            fs = (k / 2) % 4;
            sc = k % 2;
            @(posedge CLK);
            osel <= os[1:0];
            fsel <= fs[1:0];
            scr <= sc[0];
            stab = fs[0] ^ fs[1];
            // A long stop forces the stabilizer to relock on restart.
            repeat (300) @(posedge CLK);
            run <= 1'b1;
            for (int i = 0; i < 10; i++) begin
                @(posedge sclk);
                u = code ^ (fs[1] ? 16'h8000 : 16'h0000);
                e = sc[0] ? u ^ ({16{u[0]}} & 16'hFFFE) : u;
                p = ovr;
                repeat (6) @(posedge CLK);
                v = rnd();
                code <= v[15:0];
                ovr <= v[16];
                #1;
                if (i >= 6 && os == 1 && fwd1 === 1'b1) begin
                    chk("second_bus", d2, e);
                    chk("second_flag", rf2, p);
                end else if (i >= 6) begin
                    chk("first_bus", d1, e);
                    chk("flag", os[1] ? rf : rf1, p);
                end
                if (i >= 6 && os == 0) chk("fwd_low", fwd1, 1'b0);
                if (i > 6 && os == 1) chk("alternate", fwd1, !last);
                last = fwd1;
                if (i == 1) begin
                    rdr(REG_STATUS, rd, rresp);
                    chk("status", rd[6:1], {!stab, fs[1:0], os[1:0], sc[0]});
                end
            end
            if (os == 0) begin
                repeat (4) @(posedge CLK);
                #1;
                chk("capture", cap, u);
            end
            @(posedge CLK);
            run <= 1'b0;
            $display("test mode %0d format %0d scramble %0d done", os, fs, sc);
        end
        repeat (20) @(posedge CLK);
        rdr(REG_IRQ_STAT, rd, rresp);
        chk("irq_stat", rd[2:0], 3'b111);
        chk("irq_masked", irq, 1'b0);
        rdr(REG_SAMPLE, rd, rresp);
        chk("sample_reg", rd[15:0], e);
        wr(REG_IRQ_MASK, 32'h0000_0001, bresp);
        #1;
        chk("irq_high", irq, 1'b1);
        wr(REG_IRQ_STAT, 32'h0000_0007, bresp);
        rdr(REG_IRQ_STAT, rd, rresp);
        chk("irq_cleared", rd[2:0], 3'b000);
        chk("irq_low", irq, 1'b0);
        $display("test interrupts done");
        // With the enable low, encode edges must leave the output bus untouched.
        @(posedge CLK);
        ce <= 1'b0;
        run <= 1'b1;
        repeat (40) @(posedge CLK);
        run <= 1'b0;
        repeat (10) @(posedge CLK);
        #1;
        chk("freeze_data", d1, e);
        @(posedge CLK);
        ce <= 1'b1;
        $display("test clock enable done");
        end_sim();
    end
endmodule
`default_nettype wire
